// >>> logic/fesps_host.sv
// Host-side command sequencer for an asynchronous NOR flash bank with a shared
// SRAM bank. Software orders operations over APB; the block drives the pins.
// Assumes the flash pins are asynchronous to SYS_CLK and the bus resolves DQ.
// Overview of operation
// - sector erase is six writes, last one 30H at the sector address.
// - block erase is six writes ending 50H; block from address bit 15 up.
// - chip erase is six writes ending 10H at word address 5555H.
// - during erase the host only performs status polling reads.
// - on apparent completion, read twice more; both must agree.
// - program needs two unlock writes and A0H first; erase uses six writes.
// - command write: strobe low, bank select low, output gate high.
`timescale 1ns/10ps
`default_nettype none
module fesps_host #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [DATA_W-1:0] FL_DQ_I,
  output logic [DATA_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic FL_FLASH_BANK_SELECT_N,
  output logic FL_SRAM_BANK_SELECT_N
);
  import fesps_pkg::*;

  fesps_state_t state_q;
  logic [3:0] op_q, ctrl_cmd_q;
  logic start_q, done_pulse_q, busy_q, id_mode_q, poll_q, timeout_pulse_q;
  logic [2:0] step_q;
  logic [3:0] cnt_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic st_done_q, st_reject_q, st_timeout_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_stable_q;
  logic prev6_q, prev_valid_q;
  logic [1:0] agree_q;
  logic [11:0] prog_cnt_q;
  logic [19:0] seq_addr;
  logic [15:0] seq_data;
  logic [2:0] seq_len;
  logic is_flash_op, is_poll_op, apb_setup, rd_toggled, rd_match, addr_ok;

  // Bus word for the current step; unlock pair always leads
  always_comb begin
    seq_addr = ADDR_UNLOCK1;
    seq_data = DATA_UNLOCK1;
    case (step_q)
      3'h0: begin
        seq_addr = ADDR_UNLOCK1;
        seq_data = DATA_UNLOCK1;
      end
      3'h1, 3'h4: begin
        seq_addr = ADDR_UNLOCK2;
        seq_data = DATA_UNLOCK2;
      end
      3'h2: begin
        case (op_q)
          OP_PROGRAM: seq_data = CODE_PROGRAM;
          OP_ID_ENTRY: seq_data = CODE_ID_ENTRY;
          OP_ID_EXIT: seq_data = CODE_ID_EXIT;
          default: seq_data = CODE_ERASE_SETUP;
        endcase
      end
      3'h3: begin
        if (op_q == OP_PROGRAM) begin
          seq_addr = addr_q;
          seq_data = wdata_q;
        end
      end
      3'h5: begin
        case (op_q)
          OP_SECTOR_ERASE: begin
            seq_addr = addr_q & SECTOR_MASK;
            seq_data = CODE_SECTOR_ERASE;
          end
          OP_BLOCK_ERASE: begin
            seq_addr = addr_q & BLOCK_MASK;
            seq_data = CODE_BLOCK_ERASE;
          end
          default: seq_data = CODE_CHIP_ERASE; // At 5555H
        endcase
      end
      default: begin
        seq_addr = ADDR_UNLOCK1;
        seq_data = DATA_UNLOCK1;
      end
    endcase
  end

  // Sequence length and whether the operation ends in status polling
  always_comb begin
    case (op_q)
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: seq_len = LEN_ERASE;
      OP_PROGRAM: seq_len = LEN_PROGRAM;
      OP_ID_ENTRY, OP_ID_EXIT: seq_len = LEN_ID;
      default: seq_len = 3'h1;
    endcase
    is_poll_op = (op_q == OP_SECTOR_ERASE) || (op_q == OP_BLOCK_ERASE) ||
                 (op_q == OP_CHIP_ERASE) || (op_q == OP_PROGRAM);
    is_flash_op = (op_q != OP_SRAM_READ) && (op_q != OP_SRAM_WRITE);
  end

  // Status evaluation of one poll read
  always_comb begin
    rd_toggled = !prev_valid_q || (dq_stable_q[6] != prev6_q);
    if (op_q == OP_PROGRAM) begin
      rd_match = (dq_stable_q[7] == wdata_q[7]);
    end else begin
      rd_match = dq_stable_q[7];
    end
  end

  // DQ pins are asynchronous; a value counts once stages two and three agree
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
      dq_stable_q <= '0;
    end else begin
      dq_s1_q <= FL_DQ_I;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
      if (dq_s2_q == dq_s3_q) begin
        dq_stable_q <= dq_s3_q;
      end
    end
  end

  // Pin sequencer; every strobe lasts whole clock periods, far above 5 ns
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      op_q <= OP_NONE;
      step_q <= 3'h0;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      poll_q <= 1'b0;
      done_pulse_q <= 1'b0;
      timeout_pulse_q <= 1'b0;
      id_mode_q <= 1'b0;
      rdata_q <= 16'h0000;
      prev6_q <= 1'b0;
      prev_valid_q <= 1'b0;
      agree_q <= 2'h0;
      prog_cnt_q <= 12'h000;
      FL_ADDR <= '0;
      FL_DQ_O <= '0;
      FL_DQ_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_FLASH_BANK_SELECT_N <= 1'b1;
      FL_SRAM_BANK_SELECT_N <= 1'b1;
    end else begin
      done_pulse_q <= 1'b0;
      timeout_pulse_q <= 1'b0;
      // Program time bound kept while polling
      if (poll_q && op_q == OP_PROGRAM && prog_cnt_q != PROGRAM_TIMEOUT_CYC) begin
        prog_cnt_q <= prog_cnt_q + 12'h001;
      end
      case (state_q)
        S_IDLE: begin
          // Nothing new is taken while busy, so no command lands mid-operation
          if (start_q) begin
            op_q <= ctrl_cmd_q;
            busy_q <= 1'b1;
            step_q <= 3'h0;
            poll_q <= 1'b0;
            prev_valid_q <= 1'b0;
            agree_q <= 2'h0;
            prog_cnt_q <= 12'h000;
            cnt_q <= 4'h0;
            if (ctrl_cmd_q == OP_FLASH_READ || ctrl_cmd_q == OP_SRAM_READ) begin
              state_q <= S_RD_WAIT;
            end else begin
              state_q <= S_WR_SETUP;
            end
          end
        end
        S_WR_SETUP: begin
          // Gate high, bank select low, address and data set up
          FL_OE_N <= 1'b1;
          FL_DQ_OE_N <= 1'b0;
          if (op_q == OP_SRAM_WRITE) begin
            FL_ADDR <= ADDR_W'(addr_q);
            FL_DQ_O <= DATA_W'(wdata_q);
            FL_SRAM_BANK_SELECT_N <= 1'b0;
          end else begin
            FL_ADDR <= ADDR_W'(seq_addr);
            FL_DQ_O <= DATA_W'(seq_data);
            FL_FLASH_BANK_SELECT_N <= 1'b0;
          end
          cnt_q <= 4'h0;
          state_q <= S_WR_PULSE;
        end
        S_WR_PULSE: begin
          // Strobe falls after the address is stable
          FL_WE_N <= 1'b0;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == WE_PULSE_CYC) begin
            FL_WE_N <= 1'b1; // Rise latches data and may start the operation
            state_q <= S_WR_HOLD;
          end
        end
        S_WR_HOLD: begin
          // Strobe rose before select rises, so the strobe edge
          FL_FLASH_BANK_SELECT_N <= 1'b1;
          FL_SRAM_BANK_SELECT_N <= 1'b1;
          FL_DQ_OE_N <= 1'b1;
          cnt_q <= 4'h0;
          state_q <= S_GAP;
          if (is_flash_op && step_q != seq_len - 3'h1) begin
            step_q <= step_q + 3'h1;
          end else if (is_flash_op && is_poll_op) begin
            poll_q <= 1'b1; // Status valid from this strobe rise
          end else begin
            if (op_q == OP_ID_ENTRY) begin
              id_mode_q <= 1'b1;
            end
            if (op_q == OP_ID_EXIT) begin
              id_mode_q <= 1'b0;
            end
            busy_q <= 1'b0;
            done_pulse_q <= 1'b1;
          end
        end
        S_RD_WAIT: begin
          // Read cycle: a flash or SRAM read, or a status poll while the flash bank is busy
          FL_DQ_OE_N <= 1'b1;
          FL_WE_N <= 1'b1;
          FL_OE_N <= 1'b0;
          FL_ADDR <= ADDR_W'(addr_q);
          if (op_q == OP_SRAM_READ) begin
            FL_SRAM_BANK_SELECT_N <= 1'b0;
          end else begin
            FL_FLASH_BANK_SELECT_N <= 1'b0;
          end
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == READ_WAIT_CYC) begin
            FL_OE_N <= 1'b1;
            FL_FLASH_BANK_SELECT_N <= 1'b1;
            FL_SRAM_BANK_SELECT_N <= 1'b1;
            rdata_q <= 16'(dq_stable_q);
            cnt_q <= 4'h0;
            state_q <= S_GAP;
            if (!poll_q) begin
              busy_q <= 1'b0;
              done_pulse_q <= 1'b1;
            end else begin
              prev6_q <= dq_stable_q[6];
              prev_valid_q <= 1'b1;
              // First quiet read may carry stale low bits; demand two more
              if (rd_toggled || !rd_match) begin
                agree_q <= 2'h0;
              end else if (agree_q == POLL_CONFIRM) begin
                poll_q <= 1'b0;
                busy_q <= 1'b0;
                done_pulse_q <= 1'b1;
              end else begin
                agree_q <= agree_q + 2'h1;
              end
              if (op_q == OP_PROGRAM && prog_cnt_q == PROGRAM_TIMEOUT_CYC) begin
                poll_q <= 1'b0;
                busy_q <= 1'b0;
                done_pulse_q <= 1'b1;
                timeout_pulse_q <= 1'b1;
              end
            end
          end
        end
        S_GAP: begin
          // Idle time between cycles lets an aborted sequence settle
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == GAP_CYC) begin
            cnt_q <= 4'h0;
            if (poll_q) begin
              state_q <= S_RD_WAIT;
            end else if (busy_q) begin
              state_q <= S_WR_SETUP;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // APB slave: zero-wait access phase, answers registered in the setup cycle
  assign apb_setup = PSEL && !PENABLE;
  assign addr_ok = (PADDR == REG_CTRL) || (PADDR == REG_ADDR) || (PADDR == REG_WDATA) ||
                   (PADDR == REG_RDATA) || (PADDR == REG_STATUS);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup && !addr_ok;
      PRDATA <= 32'h00000000;
      if (apb_setup && !PWRITE) begin
        case (PADDR)
          REG_CTRL: PRDATA <= {28'h0000000, ctrl_cmd_q};
          REG_ADDR: PRDATA <= {12'h000, addr_q};
          REG_WDATA: PRDATA <= {16'h0000, wdata_q};
          REG_RDATA: PRDATA <= {16'h0000, rdata_q};
          REG_STATUS: PRDATA <= {27'h0000000, st_timeout_q, id_mode_q, st_reject_q,
                                 st_done_q, busy_q || start_q};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes take effect at the access edge; sticky sets beat clears
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_cmd_q <= OP_NONE;
      start_q <= 1'b0;
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      st_done_q <= 1'b0;
      st_reject_q <= 1'b0;
      st_timeout_q <= 1'b0;
    end else begin
      if (state_q == S_IDLE) begin
        start_q <= 1'b0;
      end
      if (PSEL && PENABLE && PWRITE && PREADY) begin
        case (PADDR)
          REG_CTRL: begin
            if (!busy_q && !start_q && PWDATA[3:0] != OP_NONE) begin
              ctrl_cmd_q <= PWDATA[3:0];
              start_q <= 1'b1;
            end else begin
              st_reject_q <= 1'b1;
            end
          end
          REG_ADDR: addr_q <= PWDATA[19:0];
          REG_WDATA: wdata_q <= PWDATA[15:0];
          REG_STATUS: begin
            if (PWDATA[ST_DONE]) st_done_q <= 1'b0;
            if (PWDATA[ST_REJECT]) st_reject_q <= 1'b0;
            if (PWDATA[ST_TIMEOUT]) st_timeout_q <= 1'b0;
          end
          default: ;
        endcase
      end
      if (done_pulse_q) begin
        st_done_q <= 1'b1;
      end
      if (timeout_pulse_q) begin
        st_timeout_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/fesps_pkg.sv
// Constants shared by the flash command sequencer host: register map, command
// codes, unlock pattern and bus timing.
// Assumes a 10 MHz system clock and a 20-bit word-addressed flash bank.
package fesps_pkg;
  // Own register map, byte addresses on APB
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_IDMODE = 3;
  localparam int ST_TIMEOUT = 4;
  // Software commands written to CTRL[3:0]
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h1;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h2;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h3;
  localparam logic [3:0] OP_PROGRAM = 4'h4;
  localparam logic [3:0] OP_ID_ENTRY = 4'h5;
  localparam logic [3:0] OP_ID_EXIT = 4'h6;
  localparam logic [3:0] OP_FLASH_READ = 4'h7;
  localparam logic [3:0] OP_SRAM_READ = 4'h8;
  localparam logic [3:0] OP_SRAM_WRITE = 4'h9;
  // Flash bus command words
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h05555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h02AAA;
  localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CODE_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CODE_BLOCK_ERASE = 16'h0050;
  localparam logic [15:0] CODE_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CODE_PROGRAM = 16'h00A0;
  localparam logic [15:0] CODE_ID_ENTRY = 16'h0090;
  localparam logic [15:0] CODE_ID_EXIT = 16'h00F0;
  localparam logic [19:0] SECTOR_MASK = 20'hFF800;
  localparam logic [19:0] BLOCK_MASK = 20'hF8000;
  // Sequence lengths in write cycles
  localparam logic [2:0] LEN_ERASE = 3'h6;
  localparam logic [2:0] LEN_PROGRAM = 3'h4;
  localparam logic [2:0] LEN_ID = 3'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WE_PULSE_NS = 5;
  localparam int READ_CYCLE_NS = 90;
  localparam int PROGRAM_MAX_US = 20;
  localparam int SYNC_DEPTH = 3;
  localparam int WE_PULSE_CYC_I = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC_I = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WE_PULSE_CYC = 4'(WE_PULSE_CYC_I);
  // One more cycle for the stable-value register behind the three-stage synchroniser
  localparam logic [3:0] READ_WAIT_CYC = 4'(READ_CYC_I + SYNC_DEPTH + 1);
  localparam logic [3:0] GAP_CYC = 4'(READ_CYC_I);
  localparam logic [11:0] PROGRAM_TIMEOUT_CYC = 12'(PROGRAM_MAX_US * 1000 / CLK_PERIOD_NS);
  localparam logic [1:0] POLL_CONFIRM = 2'h2;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_WR_SETUP = 6'b000010,
    S_WR_PULSE = 6'b000100,
    S_WR_HOLD = 6'b001000,
    S_RD_WAIT = 6'b010000,
    S_GAP = 6'b100000
  } fesps_state_t;
endpackage

// >>> testbench/fesps_host_asserts.sv
// Concurrent checks on the flash-side pins of the host sequencer.
// Bound to the sequencer from the bench top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module fesps_host_asserts #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [DATA_W-1:0] FL_DQ_O,
  input wire logic FL_DQ_OE_N,
  input wire logic FL_WE_N,
  input wire logic FL_OE_N,
  input wire logic FL_FLASH_BANK_SELECT_N,
  input wire logic FL_SRAM_BANK_SELECT_N
);
  logic any_sel;
  // Some bank is being addressed
  assign any_sel = !FL_FLASH_BANK_SELECT_N || !FL_SRAM_BANK_SELECT_N;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_banks_apart: assert property (FL_FLASH_BANK_SELECT_N || FL_SRAM_BANK_SELECT_N)
    else $error("both bank selects low");
  a_write_frame: assert property (!FL_WE_N |-> FL_OE_N && !FL_DQ_OE_N && any_sel)
    else $error("write strobe outside a write frame");
  a_strobe_width: assert property ($fell(FL_WE_N) |=> FL_WE_N)
    else $error("write strobe not one cycle");
  a_setup_first: assert property ($fell(FL_WE_N) |-> $past(any_sel) && $past(FL_WE_N))
    else $error("strobe fell without select setup");
  a_addr_held: assert property (!FL_WE_N |=> $stable(FL_ADDR) && $stable(FL_DQ_O) && any_sel)
    else $error("address or data moved at strobe rise");
  a_read_frame: assert property (!FL_OE_N |-> FL_WE_N && FL_DQ_OE_N && any_sel)
    else $error("output gate low during drive or strobe");
  a_read_length: assert property ($fell(FL_OE_N) |-> (!FL_OE_N)[*4])
    else $error("read shorter than four cycles");
  a_gap_after: assert property ($rose(FL_FLASH_BANK_SELECT_N) |=> !any_sel)
    else $error("no gap after flash access");
endmodule
`default_nettype wire

// >>> testbench/fesps_flash_model.sv
// Behavioural flash bank plus SRAM bank on one shared asynchronous bus.
// Expects active-low strobes; drives read data while read-gated and selected, else the last word inverted.
`timescale 1ns/10ps
`default_nettype none
module fesps_flash_model #(
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 20000,
  parameter logic [15:0] MAKER_ID = 16'h0A5C, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h0C3A // arbitrary value
) (
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic flash_sel_n,
  input wire logic sram_sel_n
);
  logic [15:0] fmem [0:1048575];
  logic [15:0] smem [0:262143];
  logic [15:0] rd, held, pdat;
  logic [19:0] lat_a;
  logic busy = 1'b0;
  logic id_mode = 1'b0;
  logic erasing = 1'b0;
  logic tgl = 1'b0;
  logic fresh = 1'b0;
  int step = 0;
  realtime t_fall;
  // Busy window; the erase itself lands at once, status reports it
  task automatic start(input int ns);
    busy <= 1'h1;
    busy <= #(ns) 1'h0;
  endtask
  task automatic wipe(input logic [19:0] base, input int n);
    for (int i = 0; i < n; i++) fmem[base + 20'(i)] = 16'hFFFF;
    erasing = 1'h1;
    start(ERASE_NS);
  endtask
  // Guarded command decoder; a wrong cycle drops back to reads
  task automatic flash_write(input logic [19:0] a, input logic [15:0] d);
    logic u1, u2;
    u1 = a == 20'h05555;
    u2 = a == 20'h02AAA;
    if (busy) return;
    case (step)
      0, 3: step = (u1 && d == 16'h00AA) ? step + 1 : 0;
      1, 4: step = (u2 && d == 16'h0055) ? step + 1 : 0;
      2: begin
        step = (u1 && d == 16'h0080) ? 3 : (u1 && d == 16'h00A0) ? 6 : 0;
        if (u1 && d == 16'h0090) id_mode = 1'h1;
        if (u1 && d == 16'h00F0) id_mode = 1'h0;
      end
      5: begin
        step = 0;
        if (d == 16'h0030) wipe(a & 20'hFF800, 2048);
        if (d == 16'h0050) wipe(a & 20'hF8000, 32768);
        if (d == 16'h0010 && u1) wipe(20'h0, 1 << 20);
      end
      default: begin
        step = 0;
        erasing = 1'h0;
        pdat = d;
        fmem[a] = fmem[a] & d;
        start(PROG_NS);
      end
    endcase
  endtask
  initial begin
    for (int i = 0; i < (1 << 20); i++) fmem[i] = 16'hFFFF;
  end
  // Address is taken as the strobe falls
  always @(negedge we_n) begin
    t_fall = $realtime;
    lat_a = addr;
  end
  // Data and command at the strobe rise; short pulses and gated cycles do nothing to the flash bank
  always @(posedge we_n) begin
    if (!flash_sel_n && oe_n && $realtime - t_fall >= 5.0) flash_write(lat_a, dq_in);
    if (!sram_sel_n) smem[lat_a[17:0]] = dq_in;
  end
  // Read value: SRAM, busy status, identity codes or the array
  always @* begin
    if (!sram_sel_n) rd = smem[addr[17:0]];
    else if (busy) rd = {8'h00, erasing ? 1'h0 : ~pdat[7], tgl, 6'h00};
    else if (fresh && !id_mode) rd = {~fmem[addr][15:8], fmem[addr][7], ~fmem[addr][6:0]};
    else if (id_mode && addr < 20'h2) rd = addr[0] ? PART_ID : MAKER_ID;
    else rd = fmem[addr];
  end
  // A released bus shows the inverse, so a stale value cannot pass
  assign dq_out = (oe_n || (flash_sel_n && sram_sel_n)) ? ~held : rd;
  // Each finished read while busy flips the alternating bit
  always @(posedge oe_n) begin
    held = rd;
    fresh = 1'b0;
    if (busy) tgl = ~tgl;
  end
  // The read right after completion shows only bit 7 true, so the host must confirm
  always @(negedge busy) fresh = 1'b1;
endmodule
`default_nettype wire

// >>> testbench/fesps_host_tb.sv
// Self-checking bench: APB orders in, behavioural flash and SRAM on the pins.
// Assumes the sequencer sets STATUS done at the end of every operation.
`timescale 1ns/10ps
`default_nettype none
module fesps_host_tb;
  import fesps_pkg::*;
  typedef struct packed {logic [3:0] op; logic [19:0] a; logic [15:0] d; logic [15:0] x;} fesps_row_t;
  localparam logic [15:0] MK = 16'h0A5C; // arbitrary value
  localparam logic [15:0] PT = 16'h0C3A; // arbitrary value
  logic SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
  logic FL_DQ_OE_N, FL_WE_N, FL_OE_N, FL_FLASH_BANK_SELECT_N, FL_SRAM_BANK_SELECT_N;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r, st;
  logic [19:0] FL_ADDR;
  logic [15:0] FL_DQ_I, FL_DQ_O, dev_dq;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  fesps_row_t rows [20] = '{
    '{OP_SRAM_WRITE, 20'h00123, 16'hA5A5, 16'h0}, '{OP_SRAM_READ, 20'h00123, 16'h0, 16'hA5A5},
    '{OP_FLASH_READ, 20'h00400, 16'h0, 16'hFFFF}, '{OP_PROGRAM, 20'h00400, 16'h1234, 16'h0},
    '{OP_FLASH_READ, 20'h00400, 16'h0, 16'h1234}, '{OP_PROGRAM, 20'h00C01, 16'h0F8F, 16'h0},
    '{OP_SECTOR_ERASE, 20'h007FF, 16'h0, 16'h0}, '{OP_FLASH_READ, 20'h00400, 16'h0, 16'hFFFF},
    '{OP_FLASH_READ, 20'h00C01, 16'h0, 16'h0F8F}, '{OP_PROGRAM, 20'h0F800, 16'h7777, 16'h0},
    '{OP_BLOCK_ERASE, 20'h0C001, 16'h0, 16'h0}, '{OP_FLASH_READ, 20'h0F800, 16'h0, 16'hFFFF},
    '{OP_FLASH_READ, 20'h00C01, 16'h0, 16'h0F8F}, '{OP_ID_ENTRY, 20'h0, 16'h0, 16'h0},
    '{OP_FLASH_READ, 20'h00000, 16'h0, MK}, '{OP_FLASH_READ, 20'h00001, 16'h0, PT},
    '{OP_ID_EXIT, 20'h0, 16'h0, 16'h0}, '{OP_FLASH_READ, 20'h00001, 16'h0, 16'hFFFF},
    '{OP_CHIP_ERASE, 20'h0, 16'h0, 16'h0}, '{OP_FLASH_READ, 20'h00C01, 16'h0, 16'hFFFF}};
  // Shared data wire: whoever is enabled drives it
  assign FL_DQ_I = FL_DQ_OE_N ? dev_dq : FL_DQ_O;
  fesps_host dut (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR), .FL_DQ_I(FL_DQ_I), .FL_DQ_O(FL_DQ_O),
    .FL_DQ_OE_N(FL_DQ_OE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N),
    .FL_FLASH_BANK_SELECT_N(FL_FLASH_BANK_SELECT_N), .FL_SRAM_BANK_SELECT_N(FL_SRAM_BANK_SELECT_N));
  fesps_flash_model dev (.addr(FL_ADDR), .dq_in(FL_DQ_I), .dq_out(dev_dq), .we_n(FL_WE_N),
    .oe_n(FL_OE_N), .flash_sel_n(FL_FLASH_BANK_SELECT_N), .sram_sel_n(FL_SRAM_BANK_SELECT_N));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    do @(posedge SYS_CLK); while (PREADY !== 1'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  // Order one operation, wait for done, clear it, fetch the last read word
  task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d);
    apb(1'h1, REG_ADDR, 32'(a));
    apb(1'h1, REG_WDATA, 32'(d));
    apb(1'h1, REG_CTRL, 32'(op));
    do apb(1'h0, REG_STATUS, 32'h0); while (r[ST_DONE] !== 1'h1);
    st = r;
    apb(1'h1, REG_STATUS, 32'h16);
    apb(1'h0, REG_RDATA, 32'h0);
  endtask
  initial begin
    SYS_CLK = 1'h0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      print_verdict();
    end
  end
  initial begin
    RST = 1'h1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    repeat (20) @(posedge SYS_CLK);
    RST <= 1'h0;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d);
      chk(32'(st[ST_TIMEOUT]), 32'h0);
      if (rows[i].op == OP_FLASH_READ || rows[i].op == OP_SRAM_READ)
        chk(r, 32'(rows[i].x));
    end
    // A second order while an erase runs is turned away; the erase must still land
    run(OP_PROGRAM, 20'h00200, 16'h5A5A);
    apb(1'h1, REG_ADDR, 32'h00200);
    apb(1'h1, REG_CTRL, 32'(OP_SECTOR_ERASE));
    apb(1'h1, REG_CTRL, 32'(OP_PROGRAM));
    apb(1'h0, REG_STATUS, 32'h0);
    chk(32'(r[ST_REJECT]), 32'h1);
    do apb(1'h0, REG_STATUS, 32'h0); while (r[ST_DONE] !== 1'h1);
    apb(1'h1, REG_STATUS, 32'h16);
    run(OP_FLASH_READ, 20'h00200, 16'h0);
    chk(r, 32'h0000FFFF);
    // Empty command is refused, unmapped address errors
    apb(1'h1, REG_CTRL, 32'h0);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(32'(r[ST_REJECT]), 32'h1);
    apb(1'h0, 8'h20, 32'h0);
    chk(32'(e), 32'h1);
    // Reset in mid-run parks every strobe and select high
    RST <= 1'h1;
    repeat (3) @(posedge SYS_CLK);
    chk(32'({FL_WE_N, FL_OE_N, FL_FLASH_BANK_SELECT_N, FL_SRAM_BANK_SELECT_N}), 32'hF);
    RST <= 1'h0;
    run(OP_SRAM_READ, 20'h00123, 16'h0);
    chk(r, 32'h0000A5A5);
    print_verdict();
  end
endmodule
bind fesps_host fesps_host_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.SYS_CLK(SYS_CLK),
  .RST(RST), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_N(FL_DQ_OE_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N), .FL_FLASH_BANK_SELECT_N(FL_FLASH_BANK_SELECT_N),
  .FL_SRAM_BANK_SELECT_N(FL_SRAM_BANK_SELECT_N));
`default_nettype wire
